// *** hw/clvemf_pkg.sv ***
// Constants, register map and types of the closed-loop velocity and back-EMF block
// How it works
// - Catch-up enable set: overspeed headroom bounded by PI terms and clip value.
// - Overspeed only in closed loop, limit off or gains/clip nonzero, deviation past tolerance.
// - Loop velocity mode ignores whether ramp runs in velocity or positioning mode.
// - Loop velocity mode active when catch-up enable and velocity mode enable both set.
// - In velocity mode, deviation beyond 768 reloads internal position to encoder plus/minus 768.
// - Velocity mode holds maximum velocity; overspeed only with nonzero deviation clip.
// - Gamma added to commutation angle in direction of motion.
// - Gamma thresholds compared against filtered mean encoder velocity.
// - EMF enable set: gamma correction applied during closed-loop operation.
// - Max gamma bounds correction; resets to 255, meaning 90 degrees.
// - Gamma zero up to minimum, linear to maximum over range, then maximum.
package clvemf_pkg;
  localparam int           ADDR_W          = 12;
  localparam int           COMM_W          = 10;
  // Register indices; byte address is four times the index
  localparam logic [9:0]   IDX_ENC_CONF    = 10'h007;
  localparam logic [9:0]   IDX_GAMMA       = 10'h01c;
  localparam logic [9:0]   IDX_MAX_RAMP_VELOCITY        = 10'h050;
  localparam logic [9:0]   IDX_TOL         = 10'h051;
  localparam logic [9:0]   IDX_STATUS      = 10'h052;
  localparam logic [9:0]   IDX_PGAIN       = 10'h05a;
  localparam logic [9:0]   IDX_IGAIN       = 10'h05b;
  localparam logic [9:0]   IDX_DVCLIP      = 10'h05e;
  localparam logic [9:0]   IDX_VMIN        = 10'h060;
  localparam logic [9:0]   IDX_VRANGE      = 10'h061;
  localparam logic [9:0]   IDX_VFILT       = 10'h063;
  localparam logic [9:0]   IDX_VENC        = 10'h065;
  localparam logic [9:0]   IDX_VMEAN       = 10'h066;
  // Fields of encoder_input_config
  localparam int           CONF_MODE_LSB   = 0;
  localparam logic [1:0]   CONF_MODE_CLOSED = 2'b01;
  localparam int           CONF_CATCHUP    = 8;
  localparam int           CONF_VELMODE    = 9;
  localparam int           CONF_EMF        = 10;
  // Fields of the filter config and status words
  localparam int           VFILT_EXP_LSB   = 8;
  localparam int           STAT_EXCEED     = 8;
  localparam int           STAT_VELMODE    = 9;
  localparam int           STAT_RELOAD     = 10;
  // Reset values and fixed figures
  localparam logic [7:0]   RST_GAMMA       = 8'hff;
  localparam logic [7:0]   RST_VF_WAIT     = 8'h40;
  localparam logic [3:0]   RST_VF_EXP      = 4'h4;
  localparam logic [31:0]  DEV_WINDOW      = 32'd768;
  localparam int           GAIN_SHIFT      = 8;
  localparam logic [2:0]   DIV_LAST_STEP   = 3'd7;
  typedef enum logic {DIV_IDLE, DIV_RUN} clvemf_div_t;
endpackage

// *** hw/clvemf_vfilter.sv ***
// Exponential mean filter for the measured encoder velocity
`timescale 1ns/10ps
`default_nettype none
module clvemf_vfilter #(
  parameter int W = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [7:0]   wait_cycles,
  input  wire logic [3:0]   filter_exp,
  input  wire logic [W-1:0] sample,
  output logic      [W-1:0] mean
);
  import clvemf_pkg::*;

  typedef struct packed {
    logic [7:0]   cnt;
    logic [W-1:0] mean;
  } clvemf_vf_t;

  clvemf_vf_t st_reg;
  clvemf_vf_t st_next;

  // Every wait_cycles+1 clocks: mean += (sample - mean) / 2^exp
  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt >= wait_cycles) begin
      st_next.cnt  = 8'h00;
      st_next.mean = st_reg.mean - W'($signed(st_reg.mean) >>> filter_exp)
                   + W'($signed(sample) >>> filter_exp);
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mean = st_reg.mean;
endmodule
`default_nettype wire

// *** hw/clvemf_top.sv ***
// Closed-loop catch-up limit, velocity mode and back-EMF gamma correction
`timescale 1ns/10ps
`default_nettype none
module clvemf_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [clvemf_pkg::ADDR_W-1:0] paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [31:0]                   encoder_position,
  input  wire logic [31:0]                   encoder_velocity,
  input  wire logic [31:0]                   internal_position,
  input  wire logic [clvemf_pkg::COMM_W-1:0] base_commutation_angle,
  output logic      [clvemf_pkg::COMM_W-1:0] commutation_angle,
  output logic      [31:0]                   velocity_limit,
  output logic                               velocity_exceed_allowed,
  output logic                               internal_position_load,
  output logic      [31:0]                   internal_position_value
);
  import clvemf_pkg::*;

  typedef struct packed {
    logic [31:0]       conf;
    logic [7:0]        gmax;
    logic [31:0]       max_ramp_velocity;
    logic [31:0]       tol;
    logic [15:0]       pgain;
    logic [15:0]       igain;
    logic [31:0]       clip;
    logic [31:0]       vmin;
    logic [31:0]       vrange;
    logic [7:0]        vf_wait;
    logic [3:0]        vf_exp;
    logic [31:0]       rdata;
    logic              err;
    logic [31:0]       isum;
    logic [31:0]       vlimit;
    logic              exceed;
    logic              load;
    logic [31:0]       load_val;
    clvemf_div_t       dstate;
    logic [2:0]        step;
    logic [39:0]       rem;
    logic [31:0]       den;
    logic [7:0]        quo;
    logic [7:0]        gamma;
    logic              gneg;
    logic              dneg;
    logic [COMM_W-1:0] comm;
  } clvemf_st_t;

  clvemf_st_t st_reg;
  clvemf_st_t st_next;

  logic [31:0] vmean;
  logic [9:0]  idx;
  logic        setup;
  logic        access;
  logic        loop_on;
  logic        lim_en;
  logic        vel_mode;
  logic        emf_on;
  logic        gains_ok;
  logic [31:0] dev;
  logic [31:0] absdev;
  logic [39:0] pprod;
  logic [39:0] iprod;
  logic [32:0] pi_sum;
  logic [32:0] isum_sum;
  logic [31:0] headroom;
  logic [32:0] vsum;
  logic [31:0] absv;
  logic [32:0] vtop;
  logic [39:0] trial;
  logic [31:0] status;

  // Mean of the measured encoder velocity
  clvemf_vfilter #(
    .W (32)
  ) u_vfilter (
    .pclk        (pclk),
    .presetn     (presetn),
    .wait_cycles (st_reg.vf_wait),
    .filter_exp  (st_reg.vf_exp),
    .sample      (encoder_velocity),
    .mean        (vmean)
  );

  // Bus phase and word index decode
  assign idx    = paddr[ADDR_W-1:2];
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // Mode decode from the encoder config word
  assign loop_on  = st_reg.conf[CONF_MODE_LSB+:2] == CONF_MODE_CLOSED;
  assign lim_en   = st_reg.conf[CONF_CATCHUP];
  assign vel_mode = lim_en && st_reg.conf[CONF_VELMODE];
  assign emf_on   = loop_on && st_reg.conf[CONF_EMF];
  assign gains_ok = (st_reg.clip != 32'h0000_0000)
                 && (st_reg.pgain != 16'h0000)
                 && (st_reg.igain != 16'h0000);

  // Signed position deviation and its magnitude
  assign dev    = internal_position - encoder_position;
  assign absdev = dev[31] ? 32'(-dev) : dev;

  // Proportional and integral catch-up terms
  assign pprod    = st_reg.pgain * absdev[23:0];
  assign iprod    = st_reg.igain * absdev[23:0];
  assign pi_sum   = {1'b0, pprod[39:GAIN_SHIFT]} + {1'b0, st_reg.isum};
  assign isum_sum = {1'b0, st_reg.isum} + {1'b0, iprod[39:GAIN_SHIFT]};

  // Overspeed headroom above the ramp maximum
  always_comb begin
    if (!lim_en) begin
      headroom = 32'hffff_ffff;
    end else if (pi_sum > {1'b0, st_reg.clip}) begin
      headroom = st_reg.clip;
    end else begin
      headroom = pi_sum[31:0];
    end
  end
  assign vsum = {1'b0, st_reg.max_ramp_velocity} + {1'b0, headroom};

  // Magnitude of mean velocity and top of the linear band
  assign absv  = vmean[31] ? 32'(-vmean) : vmean;
  assign vtop  = {1'b0, st_reg.vmin} + {1'b0, st_reg.vrange};
  assign trial = {8'h00, st_reg.den} << st_reg.step;

  // Status word
  always_comb begin
    status               = 32'h0000_0000;
    status[7:0]          = st_reg.gamma;
    status[STAT_EXCEED]  = st_reg.exceed;
    status[STAT_VELMODE] = vel_mode;
    status[STAT_RELOAD]  = st_reg.load;
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;

    // Read data and error captured in the setup phase
    if (setup) begin
      st_next.err   = 1'b0;
      st_next.rdata = 32'h0000_0000;
      if (idx == IDX_ENC_CONF) begin
        st_next.rdata = st_reg.conf;
      end else if (idx == IDX_GAMMA) begin
        st_next.rdata = {24'h000000, st_reg.gmax};
      end else if (idx == IDX_MAX_RAMP_VELOCITY) begin
        st_next.rdata = st_reg.max_ramp_velocity;
      end else if (idx == IDX_TOL) begin
        st_next.rdata = st_reg.tol;
      end else if (idx == IDX_STATUS) begin
        st_next.rdata = status;
        st_next.err   = pwrite;
      end else if (idx == IDX_PGAIN) begin
        st_next.rdata = {16'h0000, st_reg.pgain};
      end else if (idx == IDX_IGAIN) begin
        st_next.rdata = {16'h0000, st_reg.igain};
      end else if (idx == IDX_DVCLIP) begin
        st_next.rdata = st_reg.clip;
      end else if (idx == IDX_VMIN) begin
        st_next.rdata = st_reg.vmin;
      end else if (idx == IDX_VRANGE) begin
        st_next.rdata = st_reg.vrange;
      end else if (idx == IDX_VFILT) begin
        st_next.rdata = {20'h00000, st_reg.vf_exp, st_reg.vf_wait};
      end else if (idx == IDX_VENC) begin
        st_next.rdata = encoder_velocity;
        st_next.err   = pwrite;
      end else if (idx == IDX_VMEAN) begin
        st_next.rdata = vmean;
        st_next.err   = pwrite;
      end else begin
        st_next.err   = 1'b1;
      end
    end

    // Register writes at the access edge
    if (access && pwrite && !st_reg.err) begin
      if (idx == IDX_ENC_CONF) begin
        st_next.conf = pwdata;
      end else if (idx == IDX_GAMMA) begin
        st_next.gmax = pwdata[7:0];
      end else if (idx == IDX_MAX_RAMP_VELOCITY) begin
        st_next.max_ramp_velocity = pwdata;
      end else if (idx == IDX_TOL) begin
        st_next.tol = pwdata;
      end else if (idx == IDX_PGAIN) begin
        st_next.pgain = pwdata[15:0];
      end else if (idx == IDX_IGAIN) begin
        st_next.igain = pwdata[15:0];
      end else if (idx == IDX_DVCLIP) begin
        st_next.clip = pwdata;
      end else if (idx == IDX_VMIN) begin
        st_next.vmin = pwdata;
      end else if (idx == IDX_VRANGE) begin
        st_next.vrange = pwdata;
      end else if (idx == IDX_VFILT) begin
        st_next.vf_wait = pwdata[7:0];
        st_next.vf_exp  = pwdata[VFILT_EXP_LSB+:4];
      end
    end

    // Overspeed permission
    st_next.exceed = loop_on && (absdev > st_reg.tol)
                  && (!lim_en || gains_ok);

    // Integral sum grows while overspeed is allowed with catch-up enabled, clipped
    if (st_next.exceed && lim_en) begin
      if (isum_sum > {1'b0, st_reg.clip}) begin
        st_next.isum = st_reg.clip;
      end else begin
        st_next.isum = isum_sum[31:0];
      end
    end else begin
      st_next.isum = 32'h0000_0000;
    end

    // Velocity bound handed to the ramp
    if (!st_next.exceed) begin
      st_next.vlimit = st_reg.max_ramp_velocity;
    end else if (vsum[32]) begin
      st_next.vlimit = 32'hffff_ffff;
    end else begin
      st_next.vlimit = vsum[31:0];
    end

    // Internal position reload keeps the mismatch bounded
    st_next.load     = 1'b0;
    st_next.load_val = st_reg.load_val;
    if (loop_on && vel_mode && (absdev > DEV_WINDOW)) begin
      st_next.load = 1'b1;
      if (dev[31]) begin
        st_next.load_val = encoder_position - DEV_WINDOW;
      end else begin
        st_next.load_val = encoder_position + DEV_WINDOW;
      end
    end

    // Gamma from the filtered velocity, one pass after another
    case (st_reg.dstate)
      DIV_IDLE: begin
        st_next.dneg = vmean[31];
        if (!emf_on) begin
          st_next.gamma = 8'h00;
        end else if (absv <= st_reg.vmin) begin
          st_next.gamma = 8'h00;
          st_next.gneg  = vmean[31];
        end else if ({1'b0, absv} > vtop) begin
          st_next.gamma = st_reg.gmax;
          st_next.gneg  = vmean[31];
        end else begin
          st_next.rem    = st_reg.gmax * (absv - st_reg.vmin);
          st_next.den    = st_reg.vrange;
          st_next.quo    = 8'h00;
          st_next.step   = DIV_LAST_STEP;
          st_next.dstate = DIV_RUN;
        end
      end
      DIV_RUN: begin
        if (st_reg.rem >= trial) begin
          st_next.rem = st_reg.rem - trial;
          st_next.quo[st_reg.step] = 1'b1;
        end
        if (st_reg.step == 3'd0) begin
          st_next.gamma  = st_next.quo;
          st_next.gneg   = st_reg.dneg;
          st_next.dstate = DIV_IDLE;
        end else begin
          st_next.step = st_reg.step - 3'd1;
        end
      end
      default: begin
        st_next.dstate = DIV_IDLE;
      end
    endcase

    // Commutation angle leads in the direction of motion
    if (st_reg.gneg) begin
      st_next.comm = base_commutation_angle - COMM_W'(st_reg.gamma);
    end else begin
      st_next.comm = base_commutation_angle + COMM_W'(st_reg.gamma);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.gmax    <= RST_GAMMA;
      st_reg.vf_wait <= RST_VF_WAIT;
      st_reg.vf_exp  <= RST_VF_EXP;
      st_reg.dstate  <= DIV_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign prdata                  = st_reg.rdata;
  assign pready                  = 1'b1;
  assign pslverr                 = access && st_reg.err;
  assign commutation_angle       = st_reg.comm;
  assign velocity_limit          = st_reg.vlimit;
  assign velocity_exceed_allowed = st_reg.exceed;
  assign internal_position_load  = st_reg.load;
  assign internal_position_value = st_reg.load_val;
endmodule
`default_nettype wire

// *** verification/clvemf_chk.sv ***
// Port assertions for the closed-loop velocity block
`timescale 1ns/10ps
`default_nettype none
module clvemf_chk (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic [clvemf_pkg::ADDR_W-1:0] paddr,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [31:0]                   pwdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic [31:0]                   encoder_position,
  input wire logic [31:0]                   internal_position,
  input wire logic [clvemf_pkg::COMM_W-1:0] base_commutation_angle,
  input wire logic [clvemf_pkg::COMM_W-1:0] commutation_angle,
  input wire logic [31:0]                   velocity_limit,
  input wire logic                          velocity_exceed_allowed,
  input wire logic                          internal_position_load,
  input wire logic [31:0]                   internal_position_value
);
  import clvemf_pkg::*;
  logic [31:0]        conf, max_ramp_velocity_sh, tol_sh, adev, rv;
  logic signed [31:0] dev;
  logic [COMM_W-1:0]  base_q, gd;
  logic [3:0]         off_cnt;
  logic               cl, cond, exc_ok, wr;
  // Deviation, reload target and gamma seen at the ports
  assign dev    = internal_position - encoder_position;
  assign adev   = dev < 0 ? -dev : dev;
  assign rv     = dev >= 0 ? encoder_position + DEV_WINDOW : encoder_position - DEV_WINDOW;
  assign cl     = conf[1:0] == CONF_MODE_CLOSED;
  assign cond   = cl && conf[CONF_CATCHUP] && conf[CONF_VELMODE] && adev > DEV_WINDOW;
  assign exc_ok = cl && adev > tol_sh;
  assign gd     = commutation_angle - base_q;
  assign wr     = psel && penable && pwrite;
  // Shadows of written registers; count of cycles with correction off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conf    <= '0;
      max_ramp_velocity_sh <= '0;
      tol_sh  <= '0;
      base_q  <= '0;
      off_cnt <= '0;
    end else begin
      base_q  <= base_commutation_angle;
      off_cnt <= (cl && conf[CONF_EMF]) ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hf};
      if (wr && paddr[11:2] == IDX_ENC_CONF) conf <= pwdata;
      if (wr && paddr[11:2] == IDX_MAX_RAMP_VELOCITY) max_ramp_velocity_sh <= pwdata;
      if (wr && paddr[11:2] == IDX_TOL) tol_sh <= pwdata;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_ro_err;
    s_access ##0 (pwrite && paddr[11:2] == IDX_VENC) |-> pslverr;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("read-only write not refused");
  property p_reload;
    internal_position_load == $past(cond);
  endproperty
  a_reload: assert property (p_reload) else $error("reload mismatch");
  property p_reload_val;
    internal_position_load |-> internal_position_value == $past(rv);
  endproperty
  a_reload_val: assert property (p_reload_val) else $error("reload value");
  property p_exceed;
    velocity_exceed_allowed |-> $past(exc_ok);
  endproperty
  a_exceed: assert property (p_exceed) else $error("overspeed not allowed");
  property p_limit;
    !velocity_exceed_allowed |-> velocity_limit == $past(max_ramp_velocity_sh);
  endproperty
  a_limit: assert property (p_limit) else $error("limit not max_ramp_velocity");
  property p_gamma_off;
    off_cnt > 4'd11 |-> gd == '0;
  endproperty
  a_gamma_off: assert property (p_gamma_off) else $error("gamma while off");
  property p_gamma_max;
    gd <= 10'd255 || gd >= 10'd769;
  endproperty
  a_gamma_max: assert property (p_gamma_max) else $error("gamma too big");
endmodule
bind clvemf_top clvemf_chk i_clvemf_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .encoder_position(encoder_position),
  .internal_position(internal_position), .base_commutation_angle(base_commutation_angle),
  .commutation_angle(commutation_angle), .velocity_limit(velocity_limit),
  .velocity_exceed_allowed(velocity_exceed_allowed),
  .internal_position_load(internal_position_load),
  .internal_position_value(internal_position_value));
`default_nettype wire

// *** verification/clvemf_motor.sv ***
// Motor, driver and encoder stand-in for the closed-loop block
`timescale 1ns/10ps
`default_nettype none
module clvemf_motor (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          stall,
  input  wire logic [31:0]                   pos_set,
  input  wire logic [31:0]                   vel_set,
  input  wire logic [31:0]                   ipos_set,
  input  wire logic [clvemf_pkg::COMM_W-1:0] step,
  output logic      [31:0]                   encoder_position,
  output logic      [31:0]                   encoder_velocity,
  output logic      [31:0]                   internal_position,
  output logic      [clvemf_pkg::COMM_W-1:0] base_commutation_angle
);
  import clvemf_pkg::*;
  // Follows the commands a cycle late, or holds while stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_position       <= '0;
      encoder_velocity       <= '0;
      internal_position      <= '0;
      base_commutation_angle <= '0;
    end else if (!stall) begin
      encoder_position       <= pos_set;
      encoder_velocity       <= vel_set;
      internal_position      <= ipos_set;
      base_commutation_angle <= base_commutation_angle + step;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the closed-loop velocity block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import clvemf_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, stall, pready, pslverr, exc, ld;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, ep, ev, ip, e_set, v_set, i_set, vlim, lval, e;
  logic [COMM_W-1:0] base, ang, step, ge;
  logic [32:0]       q[$];
  logic [9:0]        rw[4] = '{IDX_VMIN, IDX_VRANGE, IDX_MAX_RAMP_VELOCITY, IDX_DVCLIP};
  logic [31:0]       cf[6] = '{32'h1, 32'h1, 32'h1, 32'h101, 32'h101, 32'h0};
  int                cp[6] = '{0, 0, 0, 0, 50, 0};
  int                dv[6] = '{11, 10, -11, 11, 11, 11};
  int                xe[6] = '{1, 0, 1, 0, 1, 0};
  int                rd[5] = '{769, -800, 768, -769, 800};
  int                vt[7] = '{300, -300, 150, -150, 50, 100, 200};
  int                gt[7] = '{200, -200, 100, -100, 0, 0, 200};
  int                bad_count, n_compared, k;
  clvemf_top i_clvemf_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encoder_position(ep), .encoder_velocity(ev), .internal_position(ip),
    .base_commutation_angle(base), .commutation_angle(ang), .velocity_limit(vlim),
    .velocity_exceed_allowed(exc), .internal_position_load(ld), .internal_position_value(lval));
  clvemf_motor i_clvemf_motor (.pclk(pclk), .presetn(presetn), .stall(stall), .pos_set(e_set),
    .vel_set(v_set), .ipos_set(i_set), .step(step), .encoder_position(ep),
    .encoder_velocity(ev), .internal_position(ip), .base_commutation_angle(base));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d,
                     input logic [32:0] x);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic mot(input logic [31:0] i, input logic [31:0] en);
    @(posedge pclk);
    i_set <= i;
    e_set <= en;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic close_out;
    $display("compared=%0d bad=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Scoreboard: each finished transfer against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) check({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (6000) @(posedge pclk);
    bad_count++;
    close_out;
  end
  initial begin
    {presetn, psel, penable, pwrite, stall, paddr, pwdata} = '0;
    {e_set, v_set, i_set, step} = '0;
    void'($urandom(12130));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, refused accesses, then write and read back of four registers and gamma
    apb(0, IDX_GAMMA, 0, 33'hff);
    apb(0, IDX_VFILT, 0, 33'h440);
    apb(0, IDX_ENC_CONF, 0, 33'h0);
    apb(0, 10'h3ff, 0, 33'h1_0000_0000);
    apb(1, IDX_VENC, 32'h5, 33'h1_0000_0000);
    for (k = 0; k < 4; k++) begin
      e = $urandom;
      apb(1, rw[k], e, 33'h0);
      apb(0, rw[k], 0, {1'b0, e});
    end
    e = $urandom;
    apb(1, IDX_GAMMA, e, 33'h0);
    apb(0, IDX_GAMMA, 0, {25'h0, e[7:0]});
    // Gains and limits first, then enables
    apb(1, IDX_MAX_RAMP_VELOCITY, 1000, 33'h0);
    apb(1, IDX_TOL, 10, 33'h0);
    apb(1, IDX_PGAIN, 32'h1000, 33'h0); // P term of 11 steps lands above the clip of 50
    apb(1, IDX_IGAIN, 1, 33'h0);
    for (k = 0; k < 6; k++) begin
      apb(1, IDX_DVCLIP, cp[k], 33'h0);
      apb(1, IDX_ENC_CONF, cf[k], 33'h0);
      mot(1000 + dv[k], 1000);
      check({32'h0, exc}, 33'(xe[k]));
      if (xe[k] == 0) check({1'b0, vlim}, 33'd1000);
      else check({1'b0, vlim}, cf[k][8] ? 33'd1050 : 33'h0_ffff_ffff);
    end
    // Position reload in loop velocity mode
    for (k = 0; k < 5; k++) begin
      e = $urandom & 32'h00ff_ffff;
      apb(1, IDX_ENC_CONF, k < 4 ? 32'h301 : 32'h101, 33'h0);
      mot(e + rd[k], e);
      check({32'h0, ld}, 33'(k < 4 && (rd[k] > 768 || rd[k] < -768)));
      if (ld === 1'b1) check({1'b0, lval}, {1'b0, rd[k] > 0 ? e + 768 : e - 768});
    end
    // Gamma: band 100 to 200, maximum 200, mean follows velocity at once
    mot(0, 0);
    apb(1, IDX_GAMMA, 200, 33'h0);
    apb(1, IDX_VMIN, 100, 33'h0);
    apb(1, IDX_VRANGE, 100, 33'h0);
    apb(1, IDX_VFILT, 0, 33'h0);
    apb(1, IDX_ENC_CONF, 32'h401, 33'h0);
    step <= 10'h7;
    for (k = 0; k < 7; k++) begin
      @(posedge pclk);
      stall <= 1'b1;
      v_set <= vt[k];
      repeat (4) @(posedge pclk);
      stall <= 1'b0;
      repeat (20) @(posedge pclk);
      @(negedge pclk);
      ge = base - step + COMM_W'(gt[k]);
      check({23'h0, ang}, {23'h0, ge});
    end
    apb(0, IDX_STATUS, 0, 33'hc8);
    apb(1, IDX_ENC_CONF, 32'h1, 33'h0);
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    ge = base - step;
    check({23'h0, ang}, {23'h0, ge});
    close_out;
  end
endmodule
`default_nettype wire
